// ===== lbarb_arbiter.sv
// Local bus arbitration between two controllers sharing one external bus.
// Assumes the external bus controller reports access need and busy on core_clk,
// and that the link partner runs the matching role with pull-ups on the lines.
`timescale 1ns/1ns
`default_nettype none

module lbarb_arbiter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Local bus config write and status
  input wire lbarb_pkg::lbarb_cfg_wr_t cfgWrite,
  output lbarb_pkg::lbarb_cfg_t cfgStatus,
  output logic inHold,
  // External bus controller side
  input wire lbarb_pkg::lbarb_access_t access,
  output logic busDriveEn,
  // Arbitration pins, active low except the grant output enable
  input wire logic holdRequestInN,
  input wire logic holdGrantInN,
  output logic holdGrantOutN,
  output logic holdGrantOe,
  output logic busWantOutN
);

  lbarb_pkg::lbarb_arb_state_t cur;
  lbarb_pkg::lbarb_arb_state_t next_cur;
  logic [lbarb_pkg::SYNC_W-1:0] pinLvl;
  logic holdLvl;
  logic grantLvl;
  logic holdFell;
  logic holdRose;
  logic grantFell;
  logic timerStart;
  logic [lbarb_pkg::TIMER_W-1:0] timerLoad;
  logic timerDone;

  // Partner lines pass the synchroniser before any decision
  lbarb_sync #(
    .W(lbarb_pkg::SYNC_W),
    .RESET_VAL(lbarb_pkg::SYNC_RESET)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pinIn({holdGrantInN, holdRequestInN}),
    .levelOut(pinLvl)
  );

  // Spacing of grant, request and enable pulse
  lbarb_tcl_timer #(
    .W(lbarb_pkg::TIMER_W)
  ) u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(timerStart),
    .load(timerLoad),
    .done(timerDone)
  );

  // Edge detection on filtered levels only
  assign holdLvl = pinLvl[lbarb_pkg::SYNC_HOLD_BIT];
  assign grantLvl = pinLvl[lbarb_pkg::SYNC_GRANT_BIT];
  assign holdFell = cur.holdPrev && !holdLvl;
  assign holdRose = !cur.holdPrev && holdLvl;
  assign grantFell = cur.grantPrev && !grantLvl;

  // Next state of the arbitration machine
  always_comb begin
    next_cur = cur;
    timerStart = 1'b0;
    timerLoad = lbarb_pkg::TIMER_W'(lbarb_pkg::LOCAL_CLOCK_PERIOD_CYC - 1);
    next_cur.holdPrev = holdLvl;
    next_cur.grantPrev = grantLvl;
    next_cur.busyPrev = access.extBusy;
    next_cur.arbEnPrev = cur.cfg.arbitrationEnable;
    if (cfgWrite.wr) begin
      next_cur.cfg = cfgWrite.data;
    end
    case (cur.state)
      lbarb_pkg::ST_M_NORMAL: begin
        next_cur.busDrive = 1'b1;
        next_cur.grantOutN = 1'b1;
        next_cur.busWantN = 1'b1;
        // Disabled arbitration keeps the bus through critical work
        if (cur.cfg.arbitrationEnable && holdFell) begin
          next_cur.state = lbarb_pkg::ST_M_RELEASE;
        end
      end
      lbarb_pkg::ST_M_RELEASE: begin
        // Running access completes before the bus floats
        if (cur.busDrive && !access.extBusy) begin
          next_cur.busDrive = 1'b0;
        end else if (!cur.busDrive) begin
          next_cur.grantOutN = 1'b0;
          next_cur.tclElapsed = 1'b0;
          timerStart = 1'b1;
          next_cur.state = lbarb_pkg::ST_M_HOLD;
        end
      end
      lbarb_pkg::ST_M_HOLD: begin
        if (timerDone) begin
          next_cur.tclElapsed = 1'b1;
        end
        // Level, not edge: a short pulse can rise again before the grant goes out
        if (holdLvl) begin
          next_cur.grantOutN = 1'b1;
          timerStart = 1'b1;
          next_cur.state = lbarb_pkg::ST_M_EXIT;
        end else if (access.extReq && cur.tclElapsed) begin
          next_cur.busWantN = 1'b0;
        end
      end
      lbarb_pkg::ST_M_EXIT: begin
        next_cur.busDrive = 1'b1;
        if (timerDone) begin
          next_cur.busWantN = 1'b1;
          next_cur.state = lbarb_pkg::ST_M_NORMAL;
        end
      end
      lbarb_pkg::ST_S_HOLD: begin
        next_cur.busDrive = 1'b0;
        next_cur.busWantN = 1'b1;
        if (cur.cfg.arbitrationEnable && !cur.arbEnPrev) begin
          next_cur.busWantN = 1'b0;
          timerStart = 1'b1;
          timerLoad = lbarb_pkg::TIMER_W'(lbarb_pkg::PULSE_CYC - 1);
          next_cur.state = lbarb_pkg::ST_S_PULSE;
        end else if (cur.cfg.arbitrationEnable && access.extReq && holdLvl) begin
          // Waiting for the master's request to rise grants it a full cycle
          next_cur.busWantN = 1'b0;
          next_cur.state = lbarb_pkg::ST_S_REQ;
        end
      end
      lbarb_pkg::ST_S_PULSE: begin
        if (timerDone) begin
          next_cur.busWantN = 1'b1;
          next_cur.state = lbarb_pkg::ST_S_HOLD;
        end
      end
      lbarb_pkg::ST_S_REQ: begin
        if (grantFell) begin
          next_cur.busDrive = 1'b1;
          next_cur.accessDone = 1'b0;
          next_cur.state = lbarb_pkg::ST_S_OWN;
        end
      end
      lbarb_pkg::ST_S_OWN: begin
        if (cur.busyPrev && !access.extBusy) begin
          next_cur.accessDone = 1'b1;
        end
        // Request from the master counts only after one whole access
        if (cur.accessDone && !holdLvl) begin
          next_cur.state = lbarb_pkg::ST_S_YIELD;
        end
      end
      lbarb_pkg::ST_S_YIELD: begin
        if (cur.busDrive && !access.extBusy) begin
          next_cur.busDrive = 1'b0;
        end else if (!cur.busDrive) begin
          next_cur.busWantN = 1'b1;
          next_cur.state = lbarb_pkg::ST_S_HOLD;
        end
      end
      default: begin
        next_cur.state = lbarb_pkg::ST_S_HOLD;
      end
    endcase
    // A role change restarts the machine in that role's idle state
    if (cfgWrite.wr && cfgWrite.data.arbiterRoleSelect != cur.cfg.arbiterRoleSelect) begin
      next_cur.busWantN = 1'b1;
      next_cur.grantOutN = 1'b1;
      next_cur.busDrive = cfgWrite.data.arbiterRoleSelect;
      next_cur.state = cfgWrite.data.arbiterRoleSelect ?
        lbarb_pkg::ST_M_NORMAL : lbarb_pkg::ST_S_HOLD;
    end
  end

  // Reset comes up as a floating slave
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '{state: lbarb_pkg::ST_S_HOLD,
               cfg: '{arbiterRoleSelect: lbarb_pkg::ROLE_RESET,
                      arbitrationEnable: lbarb_pkg::ARB_EN_RESET},
               arbEnPrev: lbarb_pkg::ARB_EN_RESET,
               holdPrev: 1'b1,
               grantPrev: 1'b1,
               busyPrev: 1'b0,
               accessDone: 1'b0,
               tclElapsed: 1'b0,
               busWantN: 1'b1,
               grantOutN: 1'b1,
               busDrive: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state flops, except inHold, decoded from the state
  assign cfgStatus = cur.cfg;
  assign busDriveEn = cur.busDrive;
  assign busWantOutN = cur.busWantN;
  assign holdGrantOutN = cur.grantOutN;
  assign holdGrantOe = cur.cfg.arbiterRoleSelect;
  assign inHold = (cur.state == lbarb_pkg::ST_M_HOLD) || (cur.state == lbarb_pkg::ST_S_HOLD)
    || (cur.state == lbarb_pkg::ST_S_PULSE) || (cur.state == lbarb_pkg::ST_S_REQ);

  // Checks on the arbitration sequence
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_roleByWrite;
    $rose(cur.cfg.arbiterRoleSelect) |-> $past(cfgWrite.wr && cfgWrite.data.arbiterRoleSelect);
  endproperty
  a_roleByWrite: assert property (p_roleByWrite)
    else $error("master role without a write");

  property p_ignoreWhenOff;
    (cur.state == lbarb_pkg::ST_M_NORMAL && !cur.cfg.arbitrationEnable && !cfgWrite.wr)
      |=> cur.state != lbarb_pkg::ST_M_RELEASE;
  endproperty
  a_ignoreWhenOff: assert property (p_ignoreWhenOff)
    else $error("master left normal while disabled");

  property p_slaveFloat;
    (!cur.cfg.arbiterRoleSelect && (cur.state == lbarb_pkg::ST_S_REQ || inHold)) |-> !busDriveEn;
  endproperty
  a_slaveFloat: assert property (p_slaveFloat)
    else $error("slave drives bus while in hold");

  property p_slavePins;
    cfgWrite.wr && !cfgWrite.data.arbiterRoleSelect |=> !holdGrantOe && !busDriveEn;
  endproperty
  a_slavePins: assert property (p_slavePins)
    else $error("slave role still drives grant or bus");

  property p_enablePulse;
    (cur.state == lbarb_pkg::ST_S_HOLD && $rose(cur.cfg.arbitrationEnable))
      |=> !busWantOutN [*2] ##1 busWantOutN;
  endproperty
  a_enablePulse: assert property (p_enablePulse)
    else $error("enable pulse not two periods");

  property p_grantAfterRelease;
    $fell(holdGrantOutN) |-> !busDriveEn && $past(!busDriveEn);
  endproperty
  a_grantAfterRelease: assert property (p_grantAfterRelease)
    else $error("grant before bus released");

  property p_masterReqSpacing;
    cur.cfg.arbiterRoleSelect && $fell(busWantOutN) |-> $past(!holdGrantOutN, 2);
  endproperty
  a_masterReqSpacing: assert property (p_masterReqSpacing)
    else $error("master request too soon after grant");

  property p_slaveYieldOrder;
    !cur.cfg.arbiterRoleSelect && $rose(busWantOutN) && $past(cur.state == lbarb_pkg::ST_S_YIELD)
      |-> !busDriveEn && $past(!busDriveEn);
  endproperty
  a_slaveYieldOrder: assert property (p_slaveYieldOrder)
    else $error("slave dropped request before tristate");

  property p_driveAfterGrant;
    cur.cfg.arbiterRoleSelect && $rose(holdGrantOutN) |-> !busDriveEn ##1 busDriveEn;
  endproperty
  a_driveAfterGrant: assert property (p_driveAfterGrant)
    else $error("master drive not after grant drop");

  property p_reqRelease;
    cur.cfg.arbiterRoleSelect && $rose(holdGrantOutN) && !busWantOutN |-> ##1 busWantOutN;
  endproperty
  a_reqRelease: assert property (p_reqRelease)
    else $error("master request not released one period later");

  property p_oneAccess;
    cur.state == lbarb_pkg::ST_S_OWN && !cur.accessDone && !cfgWrite.wr
      |=> cur.state == lbarb_pkg::ST_S_OWN;
  endproperty
  a_oneAccess: assert property (p_oneAccess)
    else $error("slave yielded before one access");

  property p_holdEdge;
    cur.state == lbarb_pkg::ST_M_NORMAL && cur.cfg.arbitrationEnable && holdFell && !cfgWrite.wr
      |=> cur.state == lbarb_pkg::ST_M_RELEASE;
  endproperty
  a_holdEdge: assert property (p_holdEdge)
    else $error("master missed hold request edge");

  property p_holdExit;
    cur.state == lbarb_pkg::ST_M_HOLD && holdRose && !cfgWrite.wr |=> holdGrantOutN;
  endproperty
  a_holdExit: assert property (p_holdExit)
    else $error("master kept grant after hold ended");

  c_masterHold: cover property (cur.state == lbarb_pkg::ST_M_HOLD
    ##[1:200] cur.state == lbarb_pkg::ST_M_NORMAL);
  c_slaveOwn: cover property (cur.state == lbarb_pkg::ST_S_REQ
    ##[1:200] cur.state == lbarb_pkg::ST_S_OWN);
  c_slaveYield: cover property (cur.state == lbarb_pkg::ST_S_YIELD
    ##[1:200] cur.state == lbarb_pkg::ST_S_HOLD);
  c_enablePulse: cover property (cur.state == lbarb_pkg::ST_S_PULSE);

endmodule

`default_nettype wire

// ===== lbarb_pkg.sv
// Shared constants, state codes and carrier structs for the local bus arbiter.
// Assumes one core clock, which is also the local bus clock.
package lbarb_pkg;

  // Clock and local clock period timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOCAL_CLOCK_PERIOD_NS = 8;
  localparam int LOCAL_CLOCK_PERIOD_CYC =
    (LOCAL_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_PERIODS = 2;
  localparam int PULSE_CYC = PULSE_PERIODS * LOCAL_CLOCK_PERIOD_CYC;

  // Timer and synchroniser shape
  localparam int TIMER_W = 4;
  localparam int SYNC_W = 2;
  localparam int SYNC_HOLD_BIT = 0;
  localparam int SYNC_GRANT_BIT = 1;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 2'h3;

  // Configuration reset values
  localparam logic ROLE_RESET = 1'h0;
  localparam logic ARB_EN_RESET = 1'h0;

  // Arbitration states, master and slave role
  typedef enum logic [3:0] {
    ST_M_NORMAL,
    ST_M_RELEASE,
    ST_M_HOLD,
    ST_M_EXIT,
    ST_S_HOLD,
    ST_S_PULSE,
    ST_S_REQ,
    ST_S_OWN,
    ST_S_YIELD
  } lbarb_state_t;

  // Local bus config bits as held
  typedef struct packed {
    logic arbiterRoleSelect;
    logic arbitrationEnable;
  } lbarb_cfg_t;

  // A write of the local bus config bits
  typedef struct packed {
    logic wr;
    lbarb_cfg_t data;
  } lbarb_cfg_wr_t;

  // Access status from the external bus controller
  typedef struct packed {
    logic extReq;
    logic extBusy;
  } lbarb_access_t;

  // Whole arbiter state
  typedef struct packed {
    lbarb_state_t state;
    lbarb_cfg_t cfg;
    logic arbEnPrev;
    logic holdPrev;
    logic grantPrev;
    logic busyPrev;
    logic accessDone;
    logic tclElapsed;
    logic busWantN;
    logic grantOutN;
    logic busDrive;
  } lbarb_arb_state_t;

endpackage

// ===== lbarb_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to core_clk; output is a clean level.
`timescale 1ns/1ns
`default_nettype none

module lbarb_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Raw pins and filtered levels
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] levelOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } lbarb_sync_state_t;

  lbarb_sync_state_t cur;
  lbarb_sync_state_t next_cur;

  // Level moves only where stages two and three agree; stage one feeds stage two only
  always_comb begin
    next_cur = cur;
    next_cur.s1 = pinIn;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    next_cur.lvl = (~(cur.s2 ^ cur.s3) & cur.s3) | ((cur.s2 ^ cur.s3) & cur.lvl);
  end

  // Idle high matches the pull-ups on the arbitration lines
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      cur <= next_cur;
    end
  end

  assign levelOut = cur.lvl;

endmodule

`default_nettype wire

// ===== lbarb_tcl_timer.sv
// One-shot down counter used to space arbitration edges in clock periods.
// Assumes start is a one-cycle pulse from logic on core_clk.
`timescale 1ns/1ns
`default_nettype none

module lbarb_tcl_timer #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic [W-1:0] load,
  // Expiry, one-cycle pulse
  output logic done
);

  typedef struct packed {
    logic running;
    logic [W-1:0] count;
  } lbarb_timer_state_t;

  lbarb_timer_state_t cur;
  lbarb_timer_state_t next_cur;

  // Restart wins over expiry so a fresh wait is never cut short
  always_comb begin
    next_cur = cur;
    done = cur.running && (cur.count == '0) && !start;
    if (start) begin
      next_cur.running = 1'b1;
      next_cur.count = load;
    end else if (cur.running && cur.count != '0) begin
      next_cur.count = cur.count - W'(1);
    end else if (done) begin
      next_cur.running = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

`default_nettype wire

// ===== lbarb_partner.sv
// Behavioural far-side controller for the local bus arbiter bench.
// Assumes pull-ups on the lines and that the bench picks the opposite role.
`timescale 1ns/1ns
`default_nettype none

module lbarb_partner #(
  parameter int RELEASE_DLY = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Role and bus need, from the bench
  input wire logic actAsMaster,
  input wire logic needBus,
  // Lines seen from the device
  input wire logic devWantN,
  input wire logic grantLineN,
  // Lines driven toward the device
  output logic grantOutN,
  output logic grantOe,
  output logic wantOutN
);
  logic [3:0] lowCnt;
  logic [3:0] dly;
  logic owning;

  // Grant line driven only while acting as master
  assign grantOe = actAsMaster;

  // Master or slave counterpart, one process for both roles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt <= 4'h0;
      dly <= 4'h0;
      owning <= 1'b0;
      grantOutN <= 1'b1;
      wantOutN <= 1'b1;
    end else if (actAsMaster) begin
      // Short request pulses filtered out, as a slow detector would
      lowCnt <= devWantN ? 4'h0 : ((lowCnt == 4'hf) ? lowCnt : lowCnt + 4'h1);
      if (grantOutN) begin
        if (!wantOutN) wantOutN <= 1'b1;
        if (lowCnt >= 4'h3) begin
          dly <= dly + 4'h1;
          if (dly == RELEASE_DLY[3:0]) begin
            grantOutN <= 1'b0;
            dly <= 4'h0;
          end
        end else begin
          dly <= 4'h0;
        end
      end else begin
        if (dly != 4'hf) dly <= dly + 4'h1;
        if (needBus && dly != 4'h0) wantOutN <= 1'b0;
        if (devWantN) grantOutN <= 1'b1;
      end
    end else begin
      grantOutN <= 1'b1;
      if (!owning && !wantOutN && !grantLineN) begin
        owning <= 1'b1;
      end else if (owning && !devWantN) begin
        owning <= 1'b0;
        wantOutN <= 1'b1;
      end else if (!owning && !needBus) begin
        wantOutN <= 1'b1;
      end else if (!owning && needBus && devWantN && grantLineN) begin
        wantOutN <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== lbarb_arbiter_tb_top.sv
// Self-checking bench for the local bus arbiter, both roles.
// Assumes the partner model on the far side and pull-ups on the grant line.
`timescale 1ns/1ns
`default_nettype none

module lbarb_arbiter_tb_top;
  logic core_clk;
  logic resetn;
  lbarb_pkg::lbarb_cfg_wr_t cfgWrite;
  lbarb_pkg::lbarb_cfg_t cfgStatus;
  lbarb_pkg::lbarb_access_t access;
  logic inHold, busDriveEn, dutGrantOutN, dutGrantOe, busWantOutN;
  logic pGrantOutN, pGrantOe, pWantN, grantLine, pMaster, pNeed;
  int error_cnt, tests_run, n, m;

  // Grant wire with pull-up, resolved from both enables
  assign grantLine = (dutGrantOe ? dutGrantOutN : 1'b1) & (pGrantOe ? pGrantOutN : 1'b1);

  lbarb_arbiter i_lbarb_arbiter (
    .core_clk(core_clk), .resetn(resetn), .cfgWrite(cfgWrite), .cfgStatus(cfgStatus),
    .inHold(inHold), .access(access), .busDriveEn(busDriveEn),
    .holdRequestInN(pWantN), .holdGrantInN(grantLine), .holdGrantOutN(dutGrantOutN),
    .holdGrantOe(dutGrantOe), .busWantOutN(busWantOutN)
  );

  lbarb_partner i_lbarb_partner (
    .core_clk(core_clk), .resetn(resetn), .actAsMaster(pMaster), .needBus(pNeed),
    .devWantN(busWantOutN), .grantLineN(grantLine), .grantOutN(pGrantOutN),
    .grantOe(pGrantOe), .wantOutN(pWantN)
  );

  // Clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Reset with the partner already in its role
  task automatic do_reset(input logic farMaster);
    resetn = 1'b0;
    pMaster = farMaster;
    pNeed = 1'b0;
    cfgWrite = '0;
    access = '0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
  endtask

  task automatic write_cfg(input logic role, input logic en);
    @(negedge core_clk);
    cfgWrite = {1'b1, role, en};
    @(negedge core_clk);
    cfgWrite.wr = 1'b0;
  endtask

  task automatic t_reset;
    do_reset(1'b1);
    check(cfgStatus, 8'h0);
    check(dutGrantOe, 1'b0);
    access.extReq = 1'b1;
    repeat (10) @(negedge core_clk);
    check(busDriveEn, 1'b0);
    check(busWantOutN, 1'b1);
    check(inHold, 1'b1);
    $display("Test reset done, mismatches %0d", error_cnt);
  endtask

  task automatic t_slave;
    do_reset(1'b1);
    write_cfg(1'b0, 1'b1);
    m = 0;
    repeat (8) begin
      if (busWantOutN === 1'b0) m++;
      @(negedge core_clk);
    end
    check(m, 2);
    check(cfgStatus, 8'h1);
    check(dutGrantOe, 1'b0);
    check(busDriveEn, 1'b0);
    access.extReq = 1'b1;
    for (n = 0; n < 10 && busWantOutN !== 1'b0; n++) @(negedge core_clk);
    check(n < 10, 1'b1);
    for (n = 0; n < 30 && busDriveEn !== 1'b1; n++) @(negedge core_clk);
    check(grantLine, 1'b0);
    check(inHold, 1'b0);
    // Master asks back before the slave has done any access
    pNeed = 1'b1;
    repeat (10) @(negedge core_clk);
    check(pWantN, 1'b0);
    check(busDriveEn, 1'b1);
    access.extBusy = 1'b1;
    repeat (3) @(negedge core_clk);
    access.extBusy = 1'b0;
    for (n = 0; n < 10 && busDriveEn !== 1'b0; n++) @(negedge core_clk);
    check(busWantOutN, 1'b0);
    for (n = 0; n < 5 && busWantOutN !== 1'b1; n++) @(negedge core_clk);
    check(n < 5, 1'b1);
    // No new request while the master still holds its request
    m = 0;
    repeat (10) begin
      if (busWantOutN === 1'b0 && pWantN === 1'b0) m++;
      @(negedge core_clk);
    end
    check(m, 0);
    pNeed = 1'b0;
    access = '0;
    $display("Test slave done, mismatches %0d", error_cnt);
  endtask

  task automatic t_master;
    do_reset(1'b0);
    write_cfg(1'b1, 1'b0);
    access.extBusy = 1'b1;
    pNeed = 1'b1;
    repeat (20) @(negedge core_clk);
    check(cfgStatus, 8'h2);
    check(dutGrantOe, 1'b1);
    check(dutGrantOutN, 1'b1);
    check(busDriveEn, 1'b1);
    pNeed = 1'b0;
    write_cfg(1'b1, 1'b1);
    repeat (6) @(negedge core_clk);
    pNeed = 1'b1;
    // Current access still running: no grant yet
    repeat (12) @(negedge core_clk);
    check(dutGrantOutN, 1'b1);
    access.extBusy = 1'b0;
    access.extReq = 1'b1;
    m = 1;
    for (n = 0; n < 20 && dutGrantOutN !== 1'b0; n++) begin
      m = busDriveEn;
      @(negedge core_clk);
    end
    check({m[0], busDriveEn}, 8'h0);
    check(inHold, 1'b1);
    for (n = 0; n < 10 && busWantOutN !== 1'b0; n++) @(negedge core_clk);
    check(n >= 2 && n < 10, 1'b1);
    for (n = 0; n < 20 && dutGrantOutN !== 1'b1; n++) @(negedge core_clk);
    check(busDriveEn, 1'b0);
    check(busWantOutN, 1'b0);
    @(negedge core_clk);
    check(busDriveEn, 1'b1);
    check(busWantOutN, 1'b1);
    pNeed = 1'b0;
    access = '0;
    $display("Test master done, mismatches %0d", error_cnt);
  endtask

  // Watchdog, well past the few hundred cycles the tests take
  initial begin
    #(3000 * 8);
    error_cnt++;
    $display("Watchdog expired at %0t", $time);
    finish_test();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    tests_run = 0;
    t_reset();
    t_slave();
    t_master();
    finish_test();
  end
endmodule
`default_nettype wire
